// ### logic/debug_trace_pin_mux.sv
// Summary of operation
// - Port C two and four GPIO when released
// - Port C three GPIO when released or SW
// - Port C zero GPIO: released, or SW without bit1
// - JTAG mode at reset and external reset
// - JTAG: data out two, in three, select four
// - Test reset on zero: JTAG, bit1 off
// - Serial Wire data both ways on four
// - Async trace on two: enabled, SW, field
// - Port C one: async trace or bit0
// - Trace bit0 for one, two, four wires
// - Trace bit1 on zero: two/four wires, field
// - Trace clock on port B zero when enabled
// - Port B zero feeds interrupt A
// - Interrupt D default zero; C, D selectable
// - Pull-ups on debug inputs and on async trace pin two
// - Test clock pull-down; also serial clock
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module debug_trace_pin_mux (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WRITE_I,
   input wire logic REG_READ_I,
   output logic [31:0] REG_RDATA_O,
   // Pad inputs
   input wire logic [23:0] PAD_I,
   input wire logic EXTERNAL_RESET_N_I,
   input wire logic JTAG_TEST_CLOCK_I,
   // Pad drive
   output logic [4:0] PORT_C_O,
   output logic [4:0] PORT_C_OE_O,
   output logic [4:0] PORT_C_PULLUP_O,
   output logic PORT_B_BIT_ZERO_O,
   output logic PORT_B_BIT_ZERO_OE_O,
   output logic JTAG_TEST_CLOCK_PULLDOWN_O,
   // Core side
   input wire debug_trace_pin_mux_pkg::trace_cfg_s TRACE_CFG_I,
   input wire debug_trace_pin_mux_pkg::trace_sig_s TRACE_I,
   input wire debug_trace_pin_mux_pkg::debug_drive_s DEBUG_DRIVE_I,
   output debug_trace_pin_mux_pkg::debug_pins_s DEBUG_PINS_O,
   // External interrupts
   output logic EXT_INTERRUPT_A_O,
   output logic EXT_INTERRUPT_C_O,
   output logic EXT_INTERRUPT_D_O
);

   localparam int NS = debug_trace_pin_mux_pkg::NUM_PADS + 2;
   localparam int PCB = debug_trace_pin_mux_pkg::PORT_C_BASE;
   localparam int NPC = debug_trace_pin_mux_pkg::NUM_PC;

   logic [NS-1:0] sync_q;
   logic [23:0] pad;
   logic ext_reset_n;
   logic tck;
   logic tck_prev;
   logic tck_rise;
   logic mode_reset;

   debug_trace_pin_mux_pkg::debug_mode_e mode;
   debug_trace_pin_mux_pkg::debug_mode_e next_mode;
   logic jtag;
   logic sw;

   logic [5:0] ones_run;
   logic armed;
   logic [4:0] seq_count;
   logic [15:0] seq_shift;
   logic [15:0] seq_done;
   logic seq_bit;

   logic [7:0] release_cfg;
   logic [15:0] port_c_low_pin_config;
   logic [3:0] port_c_high_pin_config;
   logic [15:0] port_b_low_pin_config;
   logic [4:0] irq_c_pin_select;
   logic [4:0] irq_d_pin_select;
   logic [8:0] gpio_output;

   logic released;
   logic [3:0] pc_field [NPC];
   logic [NPC-1:0] pc_in;
   logic [NPC-1:0] pc_free;
   logic [NPC-1:0] pc_gpio_oe;
   logic pb0_in;
   logic pb0_gpio_oe;
   logic bit1_on;
   logic bit0_alt;
   logic swo_on_pc2;
   logic trst_used;
   logic trace_clk_on;

   logic [4:0] next_c_o;
   logic [4:0] next_c_oe;
   logic [4:0] next_c_pu;
   logic next_b_o;
   logic next_b_oe;
   logic [31:0] next_rdata;

   // Pads, external reset and test clock cross in
   bit_sync2 #(
      .W(NS)
   ) u_sync (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .d_i({JTAG_TEST_CLOCK_I, EXTERNAL_RESET_N_I, PAD_I}),
      .q_o(sync_q)
   );

   assign pad = sync_q[23:0];
   assign ext_reset_n = sync_q[24];
   assign tck = sync_q[25];
   assign tck_rise = tck & ~tck_prev;
   assign pb0_in = pad[debug_trace_pin_mux_pkg::PORT_B_BASE];
   assign released = release_cfg[debug_trace_pin_mux_pkg::RELEASE_BIT];
   assign jtag = (mode == debug_trace_pin_mux_pkg::MODE_JTAG);
   assign sw = (mode == debug_trace_pin_mux_pkg::MODE_SERIAL_WIRE);
   assign mode_reset = RESET_I | ~ext_reset_n;

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         tck_prev <= 1'b0;
      end else begin
         tck_prev <= tck;
      end
   end

   assign seq_bit = pad[PCB + 4];
   assign seq_done = {seq_bit, seq_shift[15:1]};

   always_ff @(posedge CLK_I) begin
      if (mode_reset) begin
         ones_run <= '0;
         armed <= 1'b0;
         seq_count <= '0;
         seq_shift <= '0;
      end else if (tck_rise && !released) begin
         seq_shift <= seq_done;
         if (seq_bit) begin
            if (ones_run != debug_trace_pin_mux_pkg::SEQ_ONES_RUN) begin
               ones_run <= ones_run + 6'h01;
            end
         end else begin
            ones_run <= '0;
         end
         if (seq_bit &&
             ones_run >= debug_trace_pin_mux_pkg::SEQ_ONES_RUN - 6'h01) begin
            armed <= 1'b1;
            seq_count <= '0;
         end else if (armed) begin
            seq_count <= seq_count + 5'h01;
            if (seq_count == debug_trace_pin_mux_pkg::SEQ_BITS - 5'h01) begin
               armed <= 1'b0;
            end
         end
      end
   end

   // Mode switch decode
   always_comb begin
      next_mode = mode;
      if (tck_rise && !released && armed &&
          seq_count == debug_trace_pin_mux_pkg::SEQ_BITS - 5'h01) begin
         if (jtag &&
             seq_done == debug_trace_pin_mux_pkg::SEQ_TO_SERIAL_WIRE) begin
            next_mode = debug_trace_pin_mux_pkg::MODE_SERIAL_WIRE;
         end else if (sw &&
                      seq_done == debug_trace_pin_mux_pkg::SEQ_TO_JTAG) begin
            next_mode = debug_trace_pin_mux_pkg::MODE_JTAG;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (mode_reset) begin
         mode <= debug_trace_pin_mux_pkg::MODE_JTAG;
      end else begin
         case (mode)
            debug_trace_pin_mux_pkg::MODE_JTAG: begin
               mode <= next_mode;
            end
            debug_trace_pin_mux_pkg::MODE_SERIAL_WIRE: begin
               mode <= next_mode;
            end
            default: begin
               mode <= debug_trace_pin_mux_pkg::MODE_JTAG;
            end
         endcase
      end
   end

   // Register writes
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         release_cfg <= '0;
         port_c_low_pin_config <= debug_trace_pin_mux_pkg::PIN_CFG_RESET;
         port_c_high_pin_config <= debug_trace_pin_mux_pkg::PIN4_CFG_RESET;
         port_b_low_pin_config <= debug_trace_pin_mux_pkg::PIN_CFG_RESET;
         irq_c_pin_select <= debug_trace_pin_mux_pkg::IRQ_C_SEL_RESET;
         irq_d_pin_select <= debug_trace_pin_mux_pkg::IRQ_D_SEL_RESET;
         gpio_output <= '0;
      end else if (REG_WRITE_I) begin
         if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_DEBUG_PIN_RELEASE) begin
            release_cfg <= REG_WDATA_I[7:0];
         end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_PORT_C_LOW_CFG) begin
            port_c_low_pin_config <= REG_WDATA_I[15:0];
         end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_PORT_C_HIGH_CFG) begin
            port_c_high_pin_config <= REG_WDATA_I[3:0];
         end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_PORT_B_LOW_CFG) begin
            port_b_low_pin_config <= REG_WDATA_I[15:0];
         end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_IRQ_C_SELECT) begin
            irq_c_pin_select <= REG_WDATA_I[4:0];
         end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_IRQ_D_SELECT) begin
            irq_d_pin_select <= REG_WDATA_I[4:0];
         end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_GPIO_OUTPUT) begin
            gpio_output <= REG_WDATA_I[8:0];
         end
      end
   end

   // Register reads; data stand for one cycle only
   always_comb begin
      next_rdata = '0;
      if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_DEBUG_PIN_RELEASE) begin
         next_rdata[7:0] = release_cfg;
      end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_PORT_C_LOW_CFG) begin
         next_rdata[15:0] = port_c_low_pin_config;
      end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_PORT_C_HIGH_CFG) begin
         next_rdata[3:0] = port_c_high_pin_config;
      end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_PORT_B_LOW_CFG) begin
         next_rdata[15:0] = port_b_low_pin_config;
      end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_IRQ_C_SELECT) begin
         next_rdata[4:0] = irq_c_pin_select;
      end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_IRQ_D_SELECT) begin
         next_rdata[4:0] = irq_d_pin_select;
      end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_GPIO_OUTPUT) begin
         next_rdata[8:0] = gpio_output;
      end else if (REG_ADDR_I == debug_trace_pin_mux_pkg::OFF_STATUS) begin
         next_rdata[debug_trace_pin_mux_pkg::ST_MODE_LSB +: 2] = mode;
         next_rdata[debug_trace_pin_mux_pkg::ST_PC_LSB +: NPC] = pc_in;
         next_rdata[debug_trace_pin_mux_pkg::ST_PB0_BIT] = pb0_in;
         next_rdata[debug_trace_pin_mux_pkg::ST_D1_BIT] = bit1_on;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         REG_RDATA_O <= '0;
      end else if (REG_READ_I) begin
         REG_RDATA_O <= next_rdata;
      end else begin
         REG_RDATA_O <= '0;
      end
   end

   // Per-pin fields and GPIO drive
   genvar gi;
   generate
      for (gi = 0; gi < NPC; gi = gi + 1) begin : g_pc
         if (gi < 4) begin : g_low
            assign pc_field[gi] = port_c_low_pin_config[4*gi +: 4];
         end else begin : g_high
            assign pc_field[gi] = port_c_high_pin_config;
         end
         assign pc_in[gi] = pad[PCB + gi];
         assign pc_gpio_oe[gi] = pc_free[gi] &&
            pc_field[gi] == debug_trace_pin_mux_pkg::CFG_GPIO_OUT;
      end
   endgenerate

   assign pb0_gpio_oe =
      port_b_low_pin_config[3:0] == debug_trace_pin_mux_pkg::CFG_GPIO_OUT;

   // Trace bit1 needs two or four wires
   assign bit1_on = TRACE_CFG_I.enable && !TRACE_CFG_I.async &&
      (TRACE_CFG_I.width == debug_trace_pin_mux_pkg::WIDTH_2 ||
       TRACE_CFG_I.width == debug_trace_pin_mux_pkg::WIDTH_4) &&
      pc_field[0] == debug_trace_pin_mux_pkg::CFG_ALT_OUT;
   // Alternate output on port C one
   assign bit0_alt = TRACE_CFG_I.enable &&
      pc_field[1] == debug_trace_pin_mux_pkg::CFG_ALT_OUT;
   // Async trace on port C two
   assign swo_on_pc2 = TRACE_CFG_I.enable && TRACE_CFG_I.async && sw &&
      pc_field[2] == debug_trace_pin_mux_pkg::CFG_ALT_OUT;
   // Test reset only without trace bit1
   assign trst_used = jtag && !bit1_on && !released;
   // Trace clock on port B zero
   assign trace_clk_on = TRACE_CFG_I.enable && !TRACE_CFG_I.async &&
      port_b_low_pin_config[3:0] == debug_trace_pin_mux_pkg::CFG_ALT_OUT;

   // Pins two and four follow release
   assign pc_free[2] = released;
   assign pc_free[4] = released;
   // Pin three also free in SW
   assign pc_free[3] = released || sw;
   assign pc_free[0] = released || (sw && !bit1_on);
   assign pc_free[1] = 1'b1;

   // Pin function select
   always_comb begin
      next_c_o = '0;
      next_c_oe = '0;
      next_c_pu = '0;
      next_b_o = 1'b0;
      next_b_oe = 1'b0;
      // Debug first, trace next, GPIO last
      // Data out on pin two in JTAG
      if (jtag && !released) begin
         next_c_o[2] = DEBUG_DRIVE_I.tdo;
         next_c_oe[2] = DEBUG_DRIVE_I.tdo_oe;
      end else if (swo_on_pc2) begin
         next_c_o[2] = TRACE_I.async_out;
         next_c_oe[2] = 1'b1;
         next_c_pu[2] = 1'b1;
      end else if (pc_gpio_oe[2]) begin
         next_c_o[2] = gpio_output[2];
         next_c_oe[2] = 1'b1;
      end
      // Bit0 or async trace on pin one
      if (bit0_alt) begin
         next_c_o[1] = TRACE_CFG_I.async ? TRACE_I.async_out : TRACE_I.bit0;
         next_c_oe[1] = 1'b1;
      end else if (pc_gpio_oe[1]) begin
         next_c_o[1] = gpio_output[1];
         next_c_oe[1] = 1'b1;
      end
      // Serial Wire data turnaround on pin four
      if (sw && !released) begin
         next_c_o[4] = DEBUG_DRIVE_I.swdio_out;
         next_c_oe[4] = DEBUG_DRIVE_I.swdio_oe;
      end else if (pc_gpio_oe[4]) begin
         next_c_o[4] = gpio_output[4];
         next_c_oe[4] = 1'b1;
      end
      if (bit1_on) begin
         next_c_o[0] = TRACE_I.bit1;
         next_c_oe[0] = 1'b1;
      end else if (pc_gpio_oe[0]) begin
         next_c_o[0] = gpio_output[0];
         next_c_oe[0] = 1'b1;
      end
      if (pc_gpio_oe[3]) begin
         next_c_o[3] = gpio_output[3];
         next_c_oe[3] = 1'b1;
      end
      next_c_pu[3] = jtag && !released;
      next_c_pu[4] = !released;
      next_c_pu[0] = trst_used;
      if (trace_clk_on) begin
         next_b_o = TRACE_I.clock;
         next_b_oe = 1'b1;
      end else if (pb0_gpio_oe) begin
         next_b_o = gpio_output[debug_trace_pin_mux_pkg::GPIO_OUT_PB0_BIT];
         next_b_oe = 1'b1;
      end
   end

   // Registered pad drive; adds one cycle to trace paths
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         PORT_C_O <= '0;
         PORT_C_OE_O <= '0;
         PORT_C_PULLUP_O <= '0;
         PORT_B_BIT_ZERO_O <= 1'b0;
         PORT_B_BIT_ZERO_OE_O <= 1'b0;
         JTAG_TEST_CLOCK_PULLDOWN_O <= 1'b0;
      end else begin
         PORT_C_O <= next_c_o;
         PORT_C_OE_O <= next_c_oe;
         PORT_C_PULLUP_O <= next_c_pu;
         PORT_B_BIT_ZERO_O <= next_b_o;
         PORT_B_BIT_ZERO_OE_O <= next_b_oe;
         JTAG_TEST_CLOCK_PULLDOWN_O <= 1'b1;
      end
   end

   // Debug core inputs; idle levels when a pin is lent out
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         DEBUG_PINS_O <= '0;
      end else begin
         // Same clock pin in either mode
         DEBUG_PINS_O.tck <= tck;
         DEBUG_PINS_O.tdi <= (jtag && !released) ? pc_in[3] : 1'b1;
         DEBUG_PINS_O.tms_swdio <= released ? 1'b1 : pc_in[4];
         DEBUG_PINS_O.trst_n <= trst_used ? pc_in[0] : 1'b1;
         DEBUG_PINS_O.serial_wire <= sw;
      end
   end

   // External interrupt routing
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         EXT_INTERRUPT_A_O <= 1'b0;
         EXT_INTERRUPT_C_O <= 1'b0;
         EXT_INTERRUPT_D_O <= 1'b0;
      end else begin
         EXT_INTERRUPT_A_O <= pb0_in;
         // Selectable sources, out of range reads low
         EXT_INTERRUPT_C_O <= (irq_c_pin_select < 5'd24) ?
            pad[irq_c_pin_select] : 1'b0;
         EXT_INTERRUPT_D_O <= (irq_d_pin_select < 5'd24) ?
            pad[irq_d_pin_select] : 1'b0;
      end
   end

endmodule : debug_trace_pin_mux

// ### logic/debug_trace_pin_mux_pkg.sv
package debug_trace_pin_mux_pkg;

   // Register offsets (byte addresses on the register port)
   localparam logic [7:0] OFF_DEBUG_PIN_RELEASE = 8'h00;
   localparam logic [7:0] OFF_PORT_C_LOW_CFG = 8'h04;
   localparam logic [7:0] OFF_PORT_C_HIGH_CFG = 8'h08;
   localparam logic [7:0] OFF_PORT_B_LOW_CFG = 8'h0C;
   localparam logic [7:0] OFF_IRQ_C_SELECT = 8'h10;
   localparam logic [7:0] OFF_IRQ_D_SELECT = 8'h14;
   localparam logic [7:0] OFF_GPIO_OUTPUT = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;

   // Field positions
   localparam int RELEASE_BIT = 5;
   localparam int REG_EN_BIT = 4;
   localparam int GPIO_OUT_PB0_BIT = 8;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_PC_LSB = 8;
   localparam int ST_PB0_BIT = 16;
   localparam int ST_D1_BIT = 24;

   // Reset values
   localparam logic [15:0] PIN_CFG_RESET = 16'h4444;
   localparam logic [3:0] PIN4_CFG_RESET = 4'h4;
   localparam logic [4:0] IRQ_C_SEL_RESET = 5'h00;
   localparam logic [4:0] IRQ_D_SEL_RESET = 5'h10;

   // Pin configuration field codes
   localparam logic [3:0] CFG_GPIO_OUT = 4'h1;
   localparam logic [3:0] CFG_ALT_OUT = 4'h9;

   // Pad vector layout
   localparam int NUM_PADS = 24;
   localparam int PORT_B_BASE = 8;
   localparam int PORT_C_BASE = 16;
   localparam int NUM_PC = 5;

   // Mode switch sequences, sent LSB first after a run of ones
   localparam logic [15:0] SEQ_TO_SERIAL_WIRE = 16'hE79E;
   localparam logic [15:0] SEQ_TO_JTAG = 16'hE73C;
   localparam logic [5:0] SEQ_ONES_RUN = 6'h32;
   localparam logic [4:0] SEQ_BITS = 5'h10;

   typedef enum logic [1:0] {
      MODE_JTAG = 2'b01,
      MODE_SERIAL_WIRE = 2'b10
   } debug_mode_e;

   typedef enum logic [1:0] {
      WIDTH_1 = 2'b00,
      WIDTH_2 = 2'b01,
      WIDTH_4 = 2'b10
   } trace_width_e;

   typedef struct packed {
      logic enable;
      logic async;
      trace_width_e width;
   } trace_cfg_s;

   typedef struct packed {
      logic clock;
      logic bit0;
      logic bit1;
      logic async_out;
   } trace_sig_s;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
      logic swdio_out;
      logic swdio_oe;
   } debug_drive_s;

   typedef struct packed {
      logic tck;
      logic tdi;
      logic tms_swdio;
      logic trst_n;
      logic serial_wire;
   } debug_pins_s;

endpackage : debug_trace_pin_mux_pkg

// ### logic/bit_sync2.sv
`timescale 1ns/1ps
module bit_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule : bit_sync2

// ### dv/debug_trace_pin_mux_properties.sv
`timescale 1ns/1ps
module debug_trace_pin_mux_properties (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WRITE_I,
   // Pins and core side
   input wire logic [23:0] PAD_I,
   input wire logic EXTERNAL_RESET_N_I,
   input wire logic [4:0] PORT_C_O,
   input wire logic [4:0] PORT_C_OE_O,
   input wire logic [4:0] PORT_C_PULLUP_O,
   input wire logic JTAG_TEST_CLOCK_PULLDOWN_O,
   input wire debug_trace_pin_mux_pkg::debug_drive_s DEBUG_DRIVE_I,
   input wire debug_trace_pin_mux_pkg::debug_pins_s DEBUG_PINS_O,
   input wire logic EXT_INTERRUPT_A_O,
   input wire logic EXT_INTERRUPT_D_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   logic [2:0] age;
   logic rel, rel_q, sw, sw_q, up, dflt;
   logic [3:0] pbh, pch, xrh;
   assign sw = DEBUG_PINS_O.serial_wire;
   assign up = (age == 3'h7);
   // Mirror of release bit; waits out the synchronisers
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         age <= 3'h0;
         rel <= 1'b0;
         dflt <= 1'b1;
      end else begin
         if (!up) age <= age + 3'h1;
         if (REG_WRITE_I && REG_ADDR_I == 8'h00) rel <= REG_WDATA_I[5];
         if (REG_WRITE_I && REG_ADDR_I == 8'h14) dflt <= 1'b0;
      end
   end
   // Histories tolerate one cycle of skew between outputs and the synchroniser delay on pads
   always_ff @(posedge CLK_I) begin
      rel_q <= rel;
      sw_q <= sw;
      pbh <= {pbh[2:0], PAD_I[8]};
      pch <= {pch[2:0], PAD_I[16]};
      xrh <= {xrh[2:0], EXTERNAL_RESET_N_I};
   end
   property p_pc4_pullup;
      up && rel == rel_q |-> PORT_C_PULLUP_O[4] == !rel;
   endproperty
   a_pc4_pullup: assert property (p_pc4_pullup)
      else $error("pin four pull-up wrong");
   property p_pc3_pullup;
      up && rel == rel_q && sw == sw_q |-> PORT_C_PULLUP_O[3] == (!rel && !sw);
   endproperty
   a_pc3_pullup: assert property (p_pc3_pullup)
      else $error("pin three pull-up wrong");
   property p_tdo;
      up && !rel && !rel_q && !sw && !sw_q |->
         PORT_C_OE_O[2] == $past(DEBUG_DRIVE_I.tdo_oe) &&
         PORT_C_O[2] == $past(DEBUG_DRIVE_I.tdo);
   endproperty
   a_tdo: assert property (p_tdo)
      else $error("test data out not on pin two");
   property p_swdio;
      up && !rel && !rel_q && sw && sw_q |->
         PORT_C_OE_O[4] == $past(DEBUG_DRIVE_I.swdio_oe) &&
         PORT_C_O[4] == $past(DEBUG_DRIVE_I.swdio_out);
   endproperty
   a_swdio: assert property (p_swdio)
      else $error("serial data not on pin four");
   property p_pulldown;
      up |-> JTAG_TEST_CLOCK_PULLDOWN_O;
   endproperty
   a_pulldown: assert property (p_pulldown)
      else $error("clock pull-down off");
   property p_irq_a;
      up && (pbh == 4'hF || pbh == 4'h0) |-> EXT_INTERRUPT_A_O == pbh[0];
   endproperty
   a_irq_a: assert property (p_irq_a)
      else $error("interrupt A not from port B zero");
   property p_irq_d;
      up && dflt && (pch == 4'hF || pch == 4'h0) |->
         EXT_INTERRUPT_D_O == pch[0];
   endproperty
   a_irq_d: assert property (p_irq_d)
      else $error("interrupt D not from port C zero");
   property p_ext_reset;
      up && xrh == 4'h0 |-> !sw;
   endproperty
   a_ext_reset: assert property (p_ext_reset)
      else $error("external reset left serial mode");
   c_serial: cover property (sw && !sw_q);
   c_release: cover property (rel && PORT_C_OE_O[4]);
   c_back: cover property (!xrh[0] && sw_q);
endmodule : debug_trace_pin_mux_properties

bind debug_trace_pin_mux debug_trace_pin_mux_properties u_props (.*);

// ### dv/swd_switch_probe.sv
`timescale 1ns/1ps
module swd_switch_probe (
   // Clock
   input wire logic clk_i,
   // Control
   input wire logic go_i,
   input wire logic [15:0] seq_i,
   // Probe pins
   output logic tck_o,
   output logic tms_o,
   output logic busy_o
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            busy_o <= 1'b1;
            // Clock stands low between frames; period of 8 cycles
            for (int i = 0; i < 66; i++) begin
               tms_o <= (i < 50) ? 1'b1 : seq_i[i-50];
               repeat (4) @(posedge clk_i);
               tck_o <= 1'b1;
               repeat (4) @(posedge clk_i);
               tck_o <= 1'b0;
            end
            tms_o <= 1'b1;
            busy_o <= 1'b0;
         end
      end
   end
endmodule : swd_switch_probe

// ### dv/tb_debug_trace_pin_mux.sv
`timescale 1ns/1ps
module tb_debug_trace_pin_mux;
   logic clk, rst, wr, rd, xrst_n, go, tck, tms, busy, b1, asy;
   logic pb_o, pb_oe, pd, irq_a, irq_c, irq_d;
   logic [7:0] addr;
   logic [31:0] wdata, rdo, seed, r;
   logic [23:0] rnd, pad;
   logic [8:0] g;
   logic [4:0] pc_o, pc_oe, pc_pu, s1, s2;
   debug_trace_pin_mux_pkg::trace_cfg_s tcfg;
   debug_trace_pin_mux_pkg::trace_sig_s tsig;
   debug_trace_pin_mux_pkg::debug_drive_s ddrv;
   debug_trace_pin_mux_pkg::debug_pins_s dpins;
   int n_errors, n_checks, cycles;
   logic [7:0] ra [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
   logic [15:0] rv [6] = '{16'h4444, 16'h0004, 16'h4444, 16'h0000,
      16'h0010, 16'h0000};
   // Pad level from every driver
   always_comb begin
      pad = rnd;
      for (int k = 0; k < 5; k++) begin
         if (pc_oe[k]) pad[16+k] = pc_o[k];
      end
      if (!pc_oe[4]) pad[20] = tms;
      if (pb_oe) pad[8] = pb_o;
   end
   debug_trace_pin_mux DUT (
      .CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WRITE_I(wr), .REG_READ_I(rd), .REG_RDATA_O(rdo), .PAD_I(pad),
      .EXTERNAL_RESET_N_I(xrst_n), .JTAG_TEST_CLOCK_I(tck),
      .PORT_C_O(pc_o), .PORT_C_OE_O(pc_oe), .PORT_C_PULLUP_O(pc_pu),
      .PORT_B_BIT_ZERO_O(pb_o), .PORT_B_BIT_ZERO_OE_O(pb_oe),
      .JTAG_TEST_CLOCK_PULLDOWN_O(pd), .TRACE_CFG_I(tcfg), .TRACE_I(tsig),
      .DEBUG_DRIVE_I(ddrv), .DEBUG_PINS_O(dpins), .EXT_INTERRUPT_A_O(irq_a),
      .EXT_INTERRUPT_C_O(irq_c), .EXT_INTERRUPT_D_O(irq_d));
   swd_switch_probe probe (.clk_i(clk), .go_i(go),
      .seq_i(debug_trace_pin_mux_pkg::SEQ_TO_SERIAL_WIRE),
      .tck_o(tck), .tms_o(tms), .busy_o(busy));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [4:0] pu_exp(logic rel, sw, swo, bit1);
      return {!rel, !rel && !sw, swo, 1'b0, !rel && !sw && !bit1};
   endfunction : pu_exp
   task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
      n_checks++;
      if (v !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, v);
      end
   endtask : chk
   task automatic wreg(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      r = rdo;
   endtask : rreg
   task automatic settle();
      repeat (5) @(posedge clk);
      #1;
   endtask : settle
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Ceiling well above the probe frame and register traffic
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      {rst, xrst_n} = 2'b11;
      {wr, rd, go} = 3'b000;
      {addr, wdata, rnd} = '0;
      {tcfg, tsig, ddrv} = '0;
      seed = 32'h0000_0062;
      {n_errors, n_checks, cycles} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rreg(ra[i]);
         chk("reset value", {16'h0000, rv[i]}, r);
      end
      rreg(8'h1C);
      chk("mode", 32'h0000_0001, r & 32'h0000_0003);
      settle();
      chk("pullups", pu_exp(0, 0, 0, 0), pc_pu);
      chk("pulldown", 1'b1, pd);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         r = xs();
         ddrv <= r[3:0];
         rnd <= r[31:8];
         settle();
         chk("data out", {ddrv.tdo_oe, ddrv.tdo}, {pc_oe[2], pc_o[2]});
         chk("jtag in", {pad[19], pad[20], pad[16], tck}, {dpins.tdi,
            dpins.tms_swdio, dpins.trst_n, dpins.tck});
      end
      wreg(8'h04, 32'h0000_4999);
      wreg(8'h0C, 32'h0000_4449);
      for (int w = 0; w < 4; w++) begin
         @(posedge clk);
         r = xs();
         asy = (w == 3);
         b1 = (w == 1 || w == 2);
         tsig <= r[3:0];
         tcfg <= {1'b1, asy, 2'(w % 3)};
         settle();
         chk("port c one", {1'b1, asy ? tsig.async_out : tsig.bit0},
            {pc_oe[1], pc_o[1]});
         chk("port c zero", {b1, b1 & tsig.bit1, b1 | pad[16]},
            {pc_oe[0], pc_o[0] & pc_oe[0], dpins.trst_n});
         chk("trace clock", {!asy, !asy & tsig.clock}, {pb_oe, pb_o & pb_oe});
         chk("debug first", ddrv.tdo, pc_o[2]);
         chk("pullups", pu_exp(0, 0, 0, b1), pc_pu);
      end
      @(posedge clk);
      tcfg <= '0;
      wreg(8'h04, 32'h0000_1911);
      wreg(8'h08, 32'h0000_0001);
      wreg(8'h0C, 32'h0000_4441);
      r = xs();
      g = r[8:0];
      wreg(8'h18, {23'h0, g});
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int k = 0; k < 1000 && (k < 3 || busy); k++)
         @(posedge clk);
      settle();
      chk("serial mode", 1'b1, dpins.serial_wire);
      rreg(8'h1C);
      chk("mode", 32'h0000_0002, r & 32'h0000_0003);
      @(posedge clk);
      r = xs();
      tcfg <= 4'b1100;
      tsig <= r[3:0];
      ddrv <= r[7:4];
      settle();
      chk("gpio three", {1'b1, g[3]}, {pc_oe[3], pc_o[3]});
      chk("gpio zero", {1'b1, g[0]}, {pc_oe[0], pc_o[0]});
      chk("async trace", {1'b1, tsig.async_out}, {pc_oe[2], pc_o[2]});
      chk("swd data", {ddrv.swdio_oe, ddrv.swdio_out & ddrv.swdio_oe},
         {pc_oe[4], pc_o[4] & pc_oe[4]});
      chk("pullups", pu_exp(0, 1, 1, 0), pc_pu);
      @(posedge clk);
      xrst_n <= 1'b0;
      settle();
      @(posedge clk);
      xrst_n <= 1'b1;
      settle();
      chk("jtag again", 1'b0, dpins.serial_wire);
      @(posedge clk);
      tcfg <= '0;
      wreg(8'h04, 32'h0000_1111);
      wreg(8'h00, 32'h0000_0020);
      settle();
      chk("released", {5'h1F, g[4:0], 5'h00}, {pc_oe, pc_o, pc_pu});
      rreg(8'h00);
      chk("release reg", 32'h0000_0020, r);
      chk("irq d default", pad[16], irq_d);
      for (int i = 0; i < 6; i++) begin
         r = xs();
         s1 = 5'(r[4:0] % 24);
         s2 = 5'(r[9:5] % 24);
         wreg(8'h10, {27'h0, s1});
         wreg(8'h14, {27'h0, s2});
         @(posedge clk);
         rnd <= r[31:8];
         settle();
         chk("interrupts", {pad[8], pad[s1], pad[s2]},
            {irq_a, irq_c, irq_d});
      end
      complete_run();
   end
endmodule : tb_debug_trace_pin_mux
